// file: logic/vfd_scan_controller.sv
// Purpose: twenty-digit display controller, host byte intake and scan
// Assumes: host request already synchronous to clock
// Notes: host may rewrite bytes while scanning; tearing is accepted
`timescale 1ns/1ps
module vfd_scan_controller #(
   parameter int LIT_CYCLES = vfd_pkg::LIT_CYCLES,
   parameter int BLANK_CYCLES = vfd_pkg::BLANK_CYCLES,
   parameter int BUSY_CYCLES = vfd_pkg::BUSY_CYCLES,
   parameter int DIGITS = vfd_pkg::DIGIT_COUNT
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire vfd_pkg::vfd_host_s host,
   output logic busy,
   output vfd_pkg::vfd_panel_s panel
);

   localparam int IDX_W = 5;
   localparam int ADDR_W = IDX_W + 1;
   localparam int BYTES = DIGITS * vfd_pkg::BANK_COUNT;
   localparam int CNT_W = $clog2(LIT_CYCLES + BLANK_CYCLES + 1);
   // select, data, strobe for each bank plus the shift itself
   localparam int LOAD_CYCLES = 7 + DIGITS * 2 * vfd_pkg::SHIFT_HALF_CYCLES;

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (LIT_CYCLES < 1 || BUSY_CYCLES < 1) begin : g_check_time
      $error("vfd_scan_controller: interval counts must be positive");
   end
   if (BLANK_CYCLES <= LOAD_CYCLES) begin : g_check_blank
      $error("vfd_scan_controller: blank interval shorter than a load");
   end
   if (DIGITS < 2 || DIGITS > (1 << IDX_W)) begin : g_check_digits
      $error("vfd_scan_controller: digit count not supported");
   end
   if (BUSY_CYCLES > 256) begin : g_check_busy
      $error("vfd_scan_controller: busy count exceeds its counter");
   end
   if (BYTES > (1 << ADDR_W)) begin : g_check_frame
      $error("vfd_scan_controller: frame does not fit its index");
   end
   // fabric clock must be no slower than the time base it stands in for
   if (vfd_pkg::CLOCK_HZ < vfd_pkg::BUS_HZ) begin : g_check_base
      $error("vfd_scan_controller: clock slower than the scan time base");
   end

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [7:0] frameMem [BYTES];

   function automatic logic [ADDR_W-1:0] frameAddr(
      input logic [IDX_W-1:0] digit,
      input logic bank
   );
      frameAddr = {digit, bank};
   endfunction

   // ---------------------------------------------------------------
   // host intake
   // ---------------------------------------------------------------
   logic requestPrev_reg;
   logic busy_reg;
   logic [7:0] busyCount_reg;
   logic [ADDR_W-1:0] writeIndex_reg;
   logic frameReady_reg;
   logic requestFall;
   logic acceptByte;
   logic lastByte;

   assign requestFall = requestPrev_reg & ~host.displaySelectRequest_n;
   assign acceptByte = requestFall & ~busy_reg;
   assign lastByte = (writeIndex_reg == ADDR_W'(BYTES - 1));
   assign busy = busy_reg;

   // reset value matches the idle-high request line
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         requestPrev_reg <= 1'b1;
      end else begin
         requestPrev_reg <= host.displaySelectRequest_n;
      end
   end

   // ---------------------------------------------------------------
   // busy timer
   // ---------------------------------------------------------------
   // requests landing while busy are dropped, there is no queue
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         busy_reg <= 1'b0;
         busyCount_reg <= 8'h00;
      end else if (acceptByte) begin
         busy_reg <= 1'b1;
         busyCount_reg <= 8'h00;
      end else if (busy_reg) begin
         if (busyCount_reg == 8'(BUSY_CYCLES - 1)) begin
            busy_reg <= 1'b0;
         end else begin
            busyCount_reg <= busyCount_reg + 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // frame store
   // ---------------------------------------------------------------
   // bytes arrive in digit order, bank 0 then bank 1 for each digit
   // no reset on the store: nothing reads it before a whole frame
   always_ff @(posedge clock) begin
      if (acceptByte) begin
         frameMem[writeIndex_reg] <= host.hostDisplayBus;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         writeIndex_reg <= '0;
         frameReady_reg <= 1'b0;
      end else if (acceptByte) begin
         if (lastByte) begin
            writeIndex_reg <= '0;
            frameReady_reg <= 1'b1;
         end else begin
            writeIndex_reg <= writeIndex_reg + ADDR_W'(1);
         end
      end
   end

   // ---------------------------------------------------------------
   // scan sequencer
   // ---------------------------------------------------------------
   vfd_pkg::vfd_scan_e state_reg;
   vfd_pkg::vfd_scan_e state_next;
   logic [IDX_W-1:0] digit_reg;
   logic [CNT_W-1:0] interval_reg;
   logic shiftStart;
   logic shiftDone;
   logic blankDone;
   logic litDone;
   logic lastDigit;
   logic intervalRestart;

   assign blankDone = (interval_reg >= CNT_W'(BLANK_CYCLES - 1));
   assign litDone = (interval_reg == CNT_W'(LIT_CYCLES - 1));
   assign lastDigit = (digit_reg == IDX_W'(DIGITS - 1));
   assign shiftStart = (state_reg == vfd_pkg::SCAN_SHIFT_START);
   assign intervalRestart = (state_next != state_reg) &&
                            (state_next == vfd_pkg::SCAN_SEL0 || state_next == vfd_pkg::SCAN_LIT);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         vfd_pkg::SCAN_IDLE: begin
            if (frameReady_reg) begin
               state_next = vfd_pkg::SCAN_SEL0;
            end
         end
         vfd_pkg::SCAN_SEL0: begin
            state_next = vfd_pkg::SCAN_DATA0;
         end
         vfd_pkg::SCAN_DATA0: begin
            state_next = vfd_pkg::SCAN_STROBE0;
         end
         vfd_pkg::SCAN_STROBE0: begin
            state_next = vfd_pkg::SCAN_SEL1;
         end
         vfd_pkg::SCAN_SEL1: begin
            state_next = vfd_pkg::SCAN_DATA1;
         end
         vfd_pkg::SCAN_DATA1: begin
            state_next = vfd_pkg::SCAN_STROBE1;
         end
         vfd_pkg::SCAN_STROBE1: begin
            state_next = vfd_pkg::SCAN_SHIFT_START;
         end
         vfd_pkg::SCAN_SHIFT_START: begin
            state_next = vfd_pkg::SCAN_SHIFT_WAIT;
         end
         vfd_pkg::SCAN_SHIFT_WAIT: begin
            if (shiftDone) begin
               state_next = vfd_pkg::SCAN_BLANK_HOLD;
            end
         end
         vfd_pkg::SCAN_BLANK_HOLD: begin
            if (blankDone) begin
               state_next = vfd_pkg::SCAN_LIT;
            end
         end
         vfd_pkg::SCAN_LIT: begin
            if (litDone) begin
               state_next = vfd_pkg::SCAN_SEL0;
            end
         end
      endcase
   end

   // scan runs beside host intake, so it never stalls for a byte
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_reg <= vfd_pkg::SCAN_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // interval timing
   // ---------------------------------------------------------------
   // blank counter starts with the load, lit counter with the light
   // it runs on in idle, where nothing reads it
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         interval_reg <= '0;
      end else if (intervalRestart) begin
         interval_reg <= '0;
      end else begin
         interval_reg <= interval_reg + CNT_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // digit index
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         digit_reg <= '0;
      end else if (state_reg == vfd_pkg::SCAN_LIT && litDone) begin
         if (lastDigit) begin
            digit_reg <= '0;
         end else begin
            digit_reg <= digit_reg + IDX_W'(1);
         end
      end
   end

   // ---------------------------------------------------------------
   // segment latch drive
   // ---------------------------------------------------------------
   logic bank0Select_reg;
   logic bank1Select_reg;
   logic loadPulse_reg;
   logic [7:0] segData_reg;
   logic blank_reg;

   // one select at a time, so a strobe never lands in both latches
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         bank0Select_reg <= 1'b0;
         bank1Select_reg <= 1'b0;
      end else begin
         unique case (state_next)
            vfd_pkg::SCAN_SEL0, vfd_pkg::SCAN_DATA0, vfd_pkg::SCAN_STROBE0: begin
               bank0Select_reg <= 1'b1;
               bank1Select_reg <= 1'b0;
            end
            vfd_pkg::SCAN_SEL1, vfd_pkg::SCAN_DATA1, vfd_pkg::SCAN_STROBE1: begin
               bank0Select_reg <= 1'b0;
               bank1Select_reg <= 1'b1;
            end
            default: begin
               bank0Select_reg <= 1'b0;
               bank1Select_reg <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // segment data and strobe
   // ---------------------------------------------------------------
   // data changes only after the select is up, held through the strobe
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         segData_reg <= vfd_pkg::SEG_IDLE;
      end else if (state_next == vfd_pkg::SCAN_DATA0) begin
         segData_reg <= frameMem[frameAddr(digit_reg, 1'b0)];
      end else if (state_next == vfd_pkg::SCAN_DATA1) begin
         segData_reg <= frameMem[frameAddr(digit_reg, 1'b1)];
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         loadPulse_reg <= 1'b0;
      end else begin
         loadPulse_reg <= (state_next == vfd_pkg::SCAN_STROBE0) ||
                          (state_next == vfd_pkg::SCAN_STROBE1);
      end
   end

   // ---------------------------------------------------------------
   // blanking
   // ---------------------------------------------------------------
   // blank covers idle and every load step; only the lit state lights
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         blank_reg <= 1'b1;
      end else begin
         blank_reg <= (state_next != vfd_pkg::SCAN_LIT);
      end
   end

   // ---------------------------------------------------------------
   // digit chain drive
   // ---------------------------------------------------------------
   logic serialBit;
   logic shiftClock;

   // digit one goes in last, so it ends at the chain input end
   vfd_digit_shifter #(
      .DIGITS(DIGITS),
      .HALF(vfd_pkg::SHIFT_HALF_CYCLES),
      .IDX_W(IDX_W)
   ) u_shifter (
      .clock(clock),
      .reset_n(reset_n),
      .start(shiftStart),
      .digitIndex(digit_reg),
      .digitSerialIn(serialBit),
      .digitShiftClock(shiftClock),
      .done(shiftDone)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_comb begin
      panel.segmentBank0Select = bank0Select_reg;
      panel.segmentBank1Select = bank1Select_reg;
      panel.segmentLoadPulse = loadPulse_reg;
      panel.segmentDataBus = segData_reg;
      panel.digitSerialIn = serialBit;
      panel.digitShiftClock = shiftClock;
      panel.displayBlank = blank_reg;
   end

endmodule

// file: logic/vfd_pkg.sv
// Purpose: shared constants and types for the display scan controller
// Assumes: one 40 MHz clock, synchronous active-low reset
// Notes: lit and blank counts derive from the clock rate below
// ---------------------------------------------------------------
// Behaviour
// - raise bank 0 select before presenting its segment byte
// - pulse the load strobe high to latch data into the selected bank
// - raise bank 1 select, then pulse the strobe to latch its byte
// - segment bytes leave on an eight-bit parallel bus
// - two ten-bit serial drivers hold digits 1-10 and 11-20
// - each digit bit is presented, then clocked in on a rising edge
// - both drivers form one chain; all twenty bits go in one load
// - exactly one digit is enabled at a time, in turn
// - display stays blanked while segment or digit data loads
// - blank high switches every segment and digit driver off
// - each digit lit about 500 us, then blanked about 100 us
// - digits scan ascending from first to twentieth, then repeat
// - on a request pulse the controller raises busy while handling it
// - busy falls when the byte is handled; host waits for that
// - byte exchange repeats until all twenty digits have content
// - scanning continues whenever no host byte is being handled
// - time base is the crystal divided by four, setting scan intervals; the code derives lit and blank counts from CLOCK_HZ instead
// ---------------------------------------------------------------
package vfd_pkg;

   // ---------------------------------------------------------------
   // time base
   // ---------------------------------------------------------------
   localparam int CLOCK_HZ = 40_000_000;
   localparam int XTAL_HZ = 4_096_000;
   localparam int BUS_DIVIDE = 4;
   localparam int BUS_HZ = XTAL_HZ / BUS_DIVIDE;
   localparam int LIT_TIME_US = 500;
   localparam int BLANK_TIME_US = 100;
   // nominal figures, so plain floor is used for both
   localparam int LIT_CYCLES = LIT_TIME_US * (CLOCK_HZ / 1_000_000);
   localparam int BLANK_CYCLES = BLANK_TIME_US * (CLOCK_HZ / 1_000_000);
   localparam int BUSY_CYCLES = 4;
   localparam int SHIFT_HALF_CYCLES = 2;

   // ---------------------------------------------------------------
   // display geometry
   // ---------------------------------------------------------------
   localparam int DIGIT_COUNT = 20;
   localparam int BANK_COUNT = 2;
   localparam int FRAME_BYTES = DIGIT_COUNT * BANK_COUNT;
   localparam logic [7:0] SEG_IDLE = 8'h00;

   typedef enum {
      SCAN_IDLE,
      SCAN_SEL0,
      SCAN_DATA0,
      SCAN_STROBE0,
      SCAN_SEL1,
      SCAN_DATA1,
      SCAN_STROBE1,
      SCAN_SHIFT_START,
      SCAN_SHIFT_WAIT,
      SCAN_BLANK_HOLD,
      SCAN_LIT
   } vfd_scan_e;

   typedef struct packed {
      logic [7:0] hostDisplayBus;
      logic displaySelectRequest_n;
   } vfd_host_s;

   typedef struct packed {
      logic segmentBank0Select;
      logic segmentBank1Select;
      logic segmentLoadPulse;
      logic [7:0] segmentDataBus;
      logic digitSerialIn;
      logic digitShiftClock;
      logic displayBlank;
   } vfd_panel_s;

endpackage

// file: logic/vfd_digit_shifter.sv
// Purpose: serial one-hot digit load into the cascaded digit drivers
// Assumes: start only while idle; digitIndex steady during a load
// Notes: bit for the last digit goes first, since it travels furthest
`timescale 1ns/1ps
module vfd_digit_shifter #(
   parameter int DIGITS = vfd_pkg::DIGIT_COUNT,
   parameter int HALF = vfd_pkg::SHIFT_HALF_CYCLES,
   parameter int IDX_W = 5
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [IDX_W-1:0] digitIndex,
   output logic digitSerialIn,
   output logic digitShiftClock,
   output logic done
);

   if (HALF < 1 || HALF > 256 || DIGITS < 2 || DIGITS > (1 << IDX_W)) begin : g_check
      $error("vfd_digit_shifter: unsupported parameters");
   end

   logic active_reg;
   logic [IDX_W-1:0] bitPos_reg;
   logic [7:0] phaseCount_reg;
   logic lastPhase;

   assign lastPhase = (phaseCount_reg == 8'(HALF - 1));

   // ---------------------------------------------------------------
   // bit walk
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         active_reg <= 1'b0;
         bitPos_reg <= '0;
         phaseCount_reg <= 8'h00;
         digitShiftClock <= 1'b0;
         digitSerialIn <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!active_reg) begin
            if (start) begin
               active_reg <= 1'b1;
               bitPos_reg <= IDX_W'(DIGITS - 1);
               phaseCount_reg <= 8'h00;
               digitShiftClock <= 1'b0;
               digitSerialIn <= (digitIndex == IDX_W'(DIGITS - 1));
            end
         end else if (!lastPhase) begin
            phaseCount_reg <= phaseCount_reg + 8'h01;
         end else if (!digitShiftClock) begin
            phaseCount_reg <= 8'h00;
            digitShiftClock <= 1'b1;
         end else begin
            phaseCount_reg <= 8'h00;
            digitShiftClock <= 1'b0;
            if (bitPos_reg == '0) begin
               // one continuous load covers both chained drivers
               active_reg <= 1'b0;
               digitSerialIn <= 1'b0;
               done <= 1'b1;
            end else begin
               bitPos_reg <= bitPos_reg - IDX_W'(1);
               digitSerialIn <= (digitIndex == bitPos_reg - IDX_W'(1));
            end
         end
      end
   end

endmodule

// file: test/vfd_scan_sva.sv
// Purpose: port assertions for the display scan controller
// Assumes: one clock, synchronous active-low reset
// Notes: interval figures arrive from the bound instance parameters
`timescale 1ns/1ps
module vfd_scan_sva #(
   parameter int LIT_CYCLES = vfd_pkg::LIT_CYCLES,
   parameter int BLANK_CYCLES = vfd_pkg::BLANK_CYCLES,
   parameter int BUSY_CYCLES = vfd_pkg::BUSY_CYCLES,
   parameter int DIGITS = vfd_pkg::DIGIT_COUNT
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire vfd_pkg::vfd_host_s host,
   input wire logic busy,
   input wire vfd_pkg::vfd_panel_s panel
);
   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   logic [15:0] busyCount, litCount, blankCount;
   logic [5:0] shiftCount, oneCount;
   logic shiftPrev, litSeen;
   always_ff @(posedge clock) begin
      if (!reset_n || !busy) begin
         busyCount <= '0;
      end else begin
         busyCount <= busyCount + 16'h0001;
      end
   end
   always_ff @(posedge clock) begin
      if (!reset_n || panel.displayBlank) begin
         litCount <= '0;
      end else begin
         litCount <= litCount + 16'h0001;
      end
   end
   always_ff @(posedge clock) begin
      if (!reset_n || !panel.displayBlank) begin
         blankCount <= '0;
      end else begin
         blankCount <= blankCount + 16'h0001;
      end
   end
   // first blank after reset is open-ended, so interval timing waits for a lit phase
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         litSeen <= 1'b0;
      end else if (!panel.displayBlank) begin
         litSeen <= 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         shiftPrev <= 1'b0;
      end else begin
         shiftPrev <= panel.digitShiftClock;
      end
   end
   always_ff @(posedge clock) begin
      if (!reset_n || !panel.displayBlank) begin
         shiftCount <= '0;
         oneCount <= '0;
      end else if (panel.digitShiftClock && !shiftPrev) begin
         shiftCount <= shiftCount + 6'h01;
         oneCount <= oneCount + {5'h00, panel.digitSerialIn};
      end
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_busy_answer: assert property ($fell(host.displaySelectRequest_n) && !busy |=> busy)
      else $error("busy did not answer a request");
   a_busy_cause: assert property ($rose(busy) |-> !$past(host.displaySelectRequest_n)
      && $past(host.displaySelectRequest_n, 2))
      else $error("busy rose without a request");
   a_busy_length: assert property ($fell(busy) |-> busyCount == BUSY_CYCLES)
      else $error("busy high for the wrong length");
   a_strobe_single: assert property (panel.segmentLoadPulse |=> !panel.segmentLoadPulse)
      else $error("load strobe longer than one cycle");
   a_strobe_bank: assert property (panel.segmentLoadPulse |->
      panel.segmentBank0Select != panel.segmentBank1Select)
      else $error("strobe without exactly one bank selected");
   a_bank_order: assert property ($rose(panel.segmentBank1Select) |->
      $past(panel.segmentBank0Select) && $past(panel.segmentLoadPulse))
      else $error("bank 1 selected before bank 0 was loaded");
   a_data_held: assert property (panel.segmentLoadPulse |-> $stable(panel.segmentDataBus)
      && $past(panel.segmentBank0Select || panel.segmentBank1Select, 2))
      else $error("segment byte not settled under its select");
   a_blank_load: assert property (panel.segmentBank0Select || panel.segmentBank1Select
      || panel.segmentLoadPulse || $rose(panel.digitShiftClock) |-> panel.displayBlank)
      else $error("load activity while display lit");
   a_shift_steady: assert property ($rose(panel.digitShiftClock) |-> $stable(panel.digitSerialIn))
      else $error("serial bit moved at shift clock rise");
   a_chain_onehot: assert property ($fell(panel.displayBlank) |->
      shiftCount == DIGITS && oneCount == 6'h01)
      else $error("digit chain load not one-hot of full length");
   a_lit_time: assert property ($rose(panel.displayBlank) |-> litCount == LIT_CYCLES)
      else $error("lit interval wrong length");
   a_blank_time: assert property ($fell(panel.displayBlank) && litSeen |->
      blankCount == BLANK_CYCLES)
      else $error("blank interval wrong length");
   c_busy_done: cover property ($fell(busy));
   c_bank1_load: cover property (panel.segmentLoadPulse && panel.segmentBank1Select);
   c_digit_lit: cover property ($fell(panel.displayBlank) && litSeen);
endmodule

bind vfd_scan_controller vfd_scan_sva #(.LIT_CYCLES(LIT_CYCLES), .BLANK_CYCLES(BLANK_CYCLES),
   .BUSY_CYCLES(BUSY_CYCLES), .DIGITS(DIGITS)) chk (.clock(clock), .reset_n(reset_n), .host(host),
   .busy(busy), .panel(panel));

// file: test/vfd_host_model.sv
// Purpose: main processor side of the display byte handshake
// Assumes: busy is a clean level from the controller
// Notes: byte stays latched between transfers, as a holding latch would
`timescale 1ns/1ps
module vfd_host_model (
   input wire logic clock,
   input wire logic busy,
   output vfd_pkg::vfd_host_s host,
   output logic stallErr
);
   localparam int DRV = 2;
   initial begin
      host.hostDisplayBus = 8'h00;
      host.displaySelectRequest_n = 1'b1;
      stallErr = 1'b0;
   end
   task automatic tick();
      @(posedge clock);
      #DRV;
   endtask
   // bounded wait; a stuck busy is flagged, never waited out
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 16) begin
         tick();
         n++;
      end
      if (busy !== lvl) begin
         stallErr = 1'b1;
      end
   endtask
   // poke fires a second request while busy, which must be dropped
   task automatic send_byte(input logic [7:0] b, input logic poke);
      wait_busy(1'b0);
      host.hostDisplayBus = b;
      tick();
      host.displaySelectRequest_n = 1'b0;
      wait_busy(1'b1);
      // request stays low through the edge that samples busy high
      tick();
      host.displaySelectRequest_n = 1'b1;
      if (poke) begin
         tick();
         host.hostDisplayBus = 8'hee;
         host.displaySelectRequest_n = 1'b0;
         tick();
         host.displaySelectRequest_n = 1'b1;
      end
      wait_busy(1'b0);
   endtask
endmodule

// file: test/testbench.sv
// Purpose: self-checking bench for the display scan controller
// Assumes: shortened lit and blank counts, host model on the byte bus
// Notes: scan results read at each fall of the blank line
`timescale 1ns/1ps
module testbench;
   localparam int LIT = 200;
   localparam int BLANK = 120;
   localparam int DRV = 2;
   typedef struct packed {
      logic [7:0] seg0;
      logic [7:0] seg1;
      logic [19:0] chain;
   } vfd_row_s;
   logic clock, reset_n, busy, stallErr;
   logic shiftPrev = 1'b0;
   vfd_pkg::vfd_host_s host;
   vfd_pkg::vfd_panel_s panel;
   logic [7:0] seg0Seen, seg1Seen;
   logic [19:0] chainSeen;
   int strobeCount, nMismatch, totalChecks;
   vfd_row_s rows [20];

   vfd_scan_controller #(.LIT_CYCLES(LIT), .BLANK_CYCLES(BLANK), .BUSY_CYCLES(4), .DIGITS(20)) DUT (
      .clock(clock), .reset_n(reset_n), .host(host), .busy(busy), .panel(panel));
   vfd_host_model hostModel (.clock(clock), .busy(busy), .host(host), .stallErr(stallErr));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ---------------------------------------------------------------
   // panel monitor
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      shiftPrev <= panel.digitShiftClock;
      if (panel.segmentLoadPulse) begin
         strobeCount <= strobeCount + 1;
         if (panel.segmentBank0Select) seg0Seen <= panel.segmentDataBus;
         if (panel.segmentBank1Select) seg1Seen <= panel.segmentDataBus;
      end
      if (panel.digitShiftClock && !shiftPrev) chainSeen <= {chainSeen[18:0], panel.digitSerialIn};
   end
   task automatic tick();
      @(posedge clock);
      #DRV;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // blank high then low marks the next digit going lit
   task automatic wait_lit();
      int n;
      n = 0;
      while (panel.displayBlank !== 1'b1 && n < 2000) begin
         tick();
         n++;
      end
      while (panel.displayBlank !== 1'b0 && n < 2000) begin
         tick();
         n++;
      end
      chk("scan stalled", 32'h0, 32'(n >= 2000));
   endtask
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      for (int d = 0; d < 20; d++) begin
         rows[d].seg0 = 8'(8'h40 + d);
         rows[d].seg1 = 8'(8'h81 + 2 * d);
         rows[d].chain = 20'h0_0001 << d;
      end
      repeat (19) @(posedge clock);
      #DRV;
      chk("busy in reset", 32'h0, 32'(busy));
      chk("blank in reset", 32'h1, 32'(panel.displayBlank));
      tick();
      reset_n = 1'b1;
      for (int i = 0; i < 39; i++) begin
         hostModel.send_byte(i[0] ? rows[i / 2].seg1 : rows[i / 2].seg0, 1'b0);
      end
      chk("blank before full frame", 32'h1, 32'(panel.displayBlank));
      chk("strobes before full frame", 32'h0, 32'(strobeCount));
      hostModel.send_byte(rows[19].seg1, 1'b0);
      foreach (rows[d]) begin
         wait_lit();
         chk("bank 0 byte", 32'(rows[d].seg0), 32'(seg0Seen));
         chk("bank 1 byte", 32'(rows[d].seg1), 32'(seg1Seen));
         chk("digit chain", 32'(rows[d].chain), 32'(chainSeen));
      end
      // rewrite during digit 1 lit; the poked byte must be lost
      wait_lit();
      chk("scan wraps to digit 1", 32'(rows[0].chain), 32'(chainSeen));
      hostModel.send_byte(8'h5a, 1'b1);
      repeat (20) wait_lit();
      chk("rewritten bank 0", 32'h5a, 32'(seg0Seen));
      chk("bank 1 untouched", 32'(rows[0].seg1), 32'(seg1Seen));
      chk("digit 1 again", 32'(rows[0].chain), 32'(chainSeen));
      chk("host handshake stall", 32'h0, 32'(stallErr));
      // reset in mid-scan drops the frame, so the panel must stay dark
      wait_lit();
      reset_n = 1'b0;
      repeat (2) tick();
      reset_n = 1'b1;
      repeat (400) tick();
      chk("blank after reset", 32'h1, 32'(panel.displayBlank));
      chk("busy after reset", 32'h0, 32'(busy));
      giveVerdict();
   end
   initial begin
      #(30000 * 25);
      nMismatch++;
      giveVerdict();
   end
endmodule
